//--- hdl/vme_slave_address_decoder.sv
// Backplane slave address decoder: splits host cycles into four areas.
// Assumes host strobes and address come straight from backplane pins.
`timescale 1ns/1ps
module vme_slave_address_decoder
    import bus_decode_pkg::*;
#(
    parameter logic [3:0] REG_QUAL   = REG_QUAL_DEFAULT,
    parameter logic [3:0] BCAST_QUAL = BCAST_QUAL_DEFAULT
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Board strap
    input  wire logic [3:0]  board_identifier,
    // Host cycle pins
    input  wire logic [31:0] host_addr,
    input  wire logic        host_addr_ext,      // 1 extended, 0 short
    input  wire logic        host_strobe_b,      // Address strobe, active low
    input  wire logic        host_long_word,     // 1 when 32-bit transfer
    input  wire logic        host_write,         // 1 write, 0 read
    input  wire logic        host_iack_b,        // Interrupt acknowledge
    // Node side requests
    input  wire logic        irq_request,        // Raise backplane interrupt
    input  wire logic        node_done,          // Target finished access
    // Decoded selects
    output logic             mem_sel,
    output logic [1:0]       mem_node,
    output logic             mem_dram,
    output logic [21:0]      mem_word,
    output logic             node_reg_sel,
    output logic [1:0]       node_reg_node,
    output logic [2:0]       reg_word,
    output logic             board_reg_sel,
    output logic             bcast_sel,
    output logic             access_write,
    // Board register strobes
    output logic             cfg_wr,
    output logic             vector_wr,
    output logic             link_load_wr,
    output logic             mem_load_wr,
    input  wire logic [7:0]  vector_wdata,
    // Host answers
    output logic             host_ack,
    output logic             host_err,
    output logic [7:0]       iack_vector,
    output logic             irq_out,
    output logic             bus_request         // Never asserted
);
    // Synchronised pins
    logic [31:0] addr_s;
    logic [4:0]  ctl_s;
    logic        ext_s, strobe_s, long_s, write_s, iack_s;
    area_type    area_d;                         // Combinational decode
    cyc_state_type state_q;
    logic [7:0]  vector_q;                       // Stored interrupt vector
    logic        irq_q;
    logic        iack_active_q;

    pin_sync #(.WIDTH(32)) u_addr_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .async_in (host_addr),
        .sync_out (addr_s)
    );
    pin_sync #(.WIDTH(5)) u_ctl_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .async_in ({host_addr_ext, ~host_strobe_b, host_long_word,
                    host_write, ~host_iack_b}),
        .sync_out (ctl_s)
    );
    assign ext_s    = ctl_s[4];
    assign strobe_s = ctl_s[3];
    assign long_s   = ctl_s[2];
    assign write_s  = ctl_s[1];
    assign iack_s   = ctl_s[0];

    // Board identifier strap is a pin too; caught through sync below
    logic [3:0] id_meta_q, id_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            id_meta_q <= 4'h0;
            id_q      <= 4'h0;
        end else begin
            id_meta_q <= board_identifier;
            id_q      <= id_meta_q;
        end
    end

    // Area decode shared by sequencer, select and acknowledge logic
    function automatic area_type decode_area(input logic [31:0] a, input logic ext,
                                             input logic [3:0] id);
        area_type r;
        r = AREA_NONE;
        if (ext) begin
            // Extended: memory area only
            if (a[EXT_MARK_BIT] && a[EXT_ID_HI:EXT_ID_LO] == id)
                r = AREA_MEMORY;
        end else if (a[SH_QUAL_HI:SH_QUAL_LO] == REG_QUAL) begin
            if (a[SH_ID_HI:SH_ID_LO] == id) begin
                if (!a[SH_BOARD_BIT])
                    r = AREA_NODE_REG;
                else if (a[SH_REG_HI:SH_REG_LO] <= BRD_LAST)
                    r = AREA_BOARD_REG;
            end
        end else if (a[SH_QUAL_HI:SH_QUAL_LO] == BCAST_QUAL) begin
            // Ignores node and board bits; same on every board
            if (a[SH_ID_HI:SH_ID_LO] == BCAST_ID_ZERO &&
                a[SH_REG_HI:SH_REG_LO] <= BC_LAST)
                r = AREA_BROADCAST;
        end
        return r;
    endfunction

    always_comb begin
        area_d = decode_area(addr_s, ext_s, id_q);
    end

    // Cycle sequencer: one acknowledge per strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (strobe_s && !iack_s && area_d != AREA_NONE)
                        state_q <= ST_ACK;
                    else if (strobe_s)
                        state_q <= ST_WAIT_END;   // Foreign or iack, stay quiet
                end
                ST_ACK: begin
                    if (node_done || !long_s || area_d != AREA_MEMORY)
                        state_q <= ST_WAIT_END;
                end
                ST_WAIT_END: begin
                    if (!strobe_s)
                        state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Registered select outputs, held through the access
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mem_sel       <= 1'b0;
            mem_node      <= 2'h0;
            mem_dram      <= 1'b0;
            mem_word      <= 22'h0;
            node_reg_sel  <= 1'b0;
            node_reg_node <= 2'h0;
            reg_word      <= 3'h0;
            board_reg_sel <= 1'b0;
            bcast_sel     <= 1'b0;
            access_write  <= 1'b0;
        end else if (state_q == ST_IDLE && strobe_s && !iack_s && long_s) begin
            mem_sel       <= area_d == AREA_MEMORY;
            mem_node      <= addr_s[EXT_NODE_HI:EXT_NODE_LO];
            mem_dram      <= addr_s[EXT_BANK_BIT];
            mem_word      <= addr_s[EXT_WORD_HI:EXT_WORD_LO];
            node_reg_sel  <= area_d == AREA_NODE_REG;
            node_reg_node <= addr_s[SH_NODE_HI:SH_NODE_LO];
            reg_word      <= addr_s[SH_REG_HI:SH_REG_LO];
            board_reg_sel <= area_d == AREA_BOARD_REG;
            bcast_sel     <= area_d == AREA_BROADCAST;
            access_write  <= write_s;
        end else if (state_q == ST_WAIT_END && !strobe_s) begin
            mem_sel       <= 1'b0;
            node_reg_sel  <= 1'b0;
            board_reg_sel <= 1'b0;
            bcast_sel     <= 1'b0;
        end
    end

    // Board register write strobes, one cycle each
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cfg_wr       <= 1'b0;
            vector_wr    <= 1'b0;
            link_load_wr <= 1'b0;
            mem_load_wr  <= 1'b0;
        end else begin
            cfg_wr       <= 1'b0;
            vector_wr    <= 1'b0;
            link_load_wr <= 1'b0;
            mem_load_wr  <= 1'b0;
            if (state_q == ST_ACK && board_reg_sel && access_write) begin
                case (reg_word)
                    BRD_CONFIG: cfg_wr       <= 1'b1;
                    BRD_VECTOR: vector_wr    <= 1'b1;
                    BRD_LINK:   link_load_wr <= 1'b1;
                    BRD_MEMLD:  mem_load_wr  <= 1'b1;
                    default:    cfg_wr       <= 1'b0;
                endcase
            end
        end
    end

    // Interrupt vector register, written at word 1
    always_ff @(posedge sys_clk) begin
        if (!rst_b)
            vector_q <= VECTOR_RESET;
        else if (state_q == ST_ACK && board_reg_sel && access_write &&
                 reg_word == BRD_VECTOR)
            vector_q <= vector_wdata;
    end

    // Interrupt line and acknowledge vector
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq_q         <= 1'b0;
            iack_active_q <= 1'b0;
            iack_vector   <= VECTOR_RESET;
        end else begin
            iack_active_q <= iack_s && strobe_s && irq_q && state_q == ST_IDLE;
            if (irq_request)
                irq_q <= 1'b1;                                    // Set wins over clear
            else if (iack_active_q)
                irq_q <= 1'b0;
            if (iack_s && strobe_s && irq_q && state_q == ST_IDLE)
                iack_vector <= vector_q;
        end
    end
    assign irq_out = irq_q;

    // Host acknowledge: data/vector or memory completion
    assign host_ack = (state_q == ST_ACK && long_s &&
                       (area_d != AREA_MEMORY || node_done)) || iack_active_q;
    assign host_err = state_q == ST_ACK && !long_s;
    assign bus_request = 1'b0;
endmodule

//--- hdl/bus_decode_pkg.sv
// Constants for the backplane slave address decoder.
// Assumes a single 50 MHz clock; host bus pins arrive asynchronously.
// Contract
// - Four address bits match board identifier
// - Node memory only via extended addressing
// - Memory fields: bit31, id, node, bank, word
// - Short accesses need matching area qualifier
// - Node register: id match, bit7 low
// - Board register: bit7 high, four words used
// - Broadcast: qualifier match, id bits zero
// - Three broadcast words shared by all boards
// - Qualifiers programmable, defaults F and E
// - Only 32-bit transfers are accepted; interrupt acknowledge at any width
// - Board never requests bus mastership
// - Interrupt acknowledge returns 8-bit vector
// - Board words: config, vector, link, memory
package bus_decode_pkg;
    localparam logic [3:0] REG_QUAL_DEFAULT   = 4'hf;   // Register-area qualifier
    localparam logic [3:0] BCAST_QUAL_DEFAULT = 4'he;   // Broadcast-area qualifier
    localparam int EXT_MARK_BIT  = 31;   // Must be set in memory area
    localparam int EXT_ID_HI     = 30;
    localparam int EXT_ID_LO     = 27;
    localparam int EXT_NODE_HI   = 26;
    localparam int EXT_NODE_LO   = 25;
    localparam int EXT_BANK_BIT  = 24;   // Low selects SRAM
    localparam int EXT_WORD_HI   = 23;
    localparam int EXT_WORD_LO   = 2;
    localparam int SH_QUAL_HI    = 15;
    localparam int SH_QUAL_LO    = 12;
    localparam int SH_ID_HI      = 11;
    localparam int SH_ID_LO      = 8;
    localparam int SH_BOARD_BIT  = 7;
    localparam int SH_NODE_HI    = 6;
    localparam int SH_NODE_LO    = 5;
    localparam int SH_REG_HI     = 4;
    localparam int SH_REG_LO     = 2;
    localparam logic [3:0] BCAST_ID_ZERO = 4'h0;
    // Board register words
    localparam logic [2:0] BRD_CONFIG = 3'h0;   // Byte address 0x80
    localparam logic [2:0] BRD_VECTOR = 3'h1;
    localparam logic [2:0] BRD_LINK   = 3'h2;
    localparam logic [2:0] BRD_MEMLD  = 3'h3;
    localparam logic [2:0] BRD_LAST   = 3'h3;
    // Broadcast words
    localparam logic [2:0] BC_WRITE   = 3'h0;
    localparam logic [2:0] BC_READ    = 3'h1;
    localparam logic [2:0] BC_INTERRO = 3'h2;
    localparam logic [2:0] BC_LAST    = 3'h2;
    localparam logic [7:0] VECTOR_RESET = 8'h00;
    typedef enum logic [2:0] {
        AREA_NONE, AREA_MEMORY, AREA_NODE_REG, AREA_BOARD_REG, AREA_BROADCAST
    } area_type;
    typedef enum { ST_IDLE, ST_ACK, ST_WAIT_END } cyc_state_type;
endpackage

//--- hdl/pin_sync.sv
// Two-flop synchroniser for a bundle of backplane inputs.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
module pin_sync
    import bus_decode_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;   // First stage, read only by second

    // Two-stage capture
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- testbench/vme_slave_address_decoder_sva.sv
// Checker for the backplane slave address decoder.
// Assumes binding to the top module; sees its ports only.
`timescale 1ns/1ps
module vme_slave_address_decoder_sva
    import bus_decode_pkg::*;
#(
    parameter logic [3:0] REG_QUAL   = REG_QUAL_DEFAULT,
    parameter logic [3:0] BCAST_QUAL = BCAST_QUAL_DEFAULT
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // Host side inputs
    input wire logic [3:0]  board_identifier,
    input wire logic [31:0] host_addr,
    input wire logic        host_addr_ext,
    input wire logic        host_long_word,
    // Decoder outputs
    input wire logic        mem_sel,
    input wire logic [1:0]  mem_node,
    input wire logic        mem_dram,
    input wire logic [21:0] mem_word,
    input wire logic        node_reg_sel,
    input wire logic [1:0]  node_reg_node,
    input wire logic [2:0]  reg_word,
    input wire logic        board_reg_sel,
    input wire logic        bcast_sel,
    input wire logic        access_write,
    input wire logic        cfg_wr,
    input wire logic        host_ack,
    input wire logic        host_err,
    input wire logic        bus_request
);
    // Host holds address while selects rise, so raw pins are comparable then
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    chk_never_master: assert property (!bus_request)
        else $error("bus request raised");
    chk_single_area: assert property ($onehot0({mem_sel, node_reg_sel, board_reg_sel, bcast_sel}))
        else $error("two areas selected");
    chk_mem_extended: assert property ($rose(mem_sel) |-> host_addr_ext && host_addr[31])
        else $error("memory select without extended mark");
    chk_mem_fields: assert property ($rose(mem_sel) |-> host_addr[30:27] == board_identifier
        && mem_node == host_addr[26:25] && mem_dram == host_addr[24] && mem_word == host_addr[23:2])
        else $error("memory fields wrong");
    chk_node_fields: assert property ($rose(node_reg_sel) |-> !host_addr_ext
        && host_addr[15:7] == {REG_QUAL, board_identifier, 1'b0}
        && node_reg_node == host_addr[6:5] && reg_word == host_addr[4:2])
        else $error("node register fields wrong");
    chk_board_fields: assert property ($rose(board_reg_sel) |->
        host_addr[15:7] == {REG_QUAL, board_identifier, 1'b1} && reg_word <= BRD_LAST)
        else $error("board register fields wrong");
    chk_bcast_fields: assert property ($rose(bcast_sel) |-> host_addr[15:8] == {BCAST_QUAL, 4'h0}
        && reg_word == host_addr[4:2] && reg_word <= BC_LAST)
        else $error("broadcast fields wrong");
    chk_node_ack: assert property ($rose(node_reg_sel) && host_long_word |-> ##[0:1] host_ack)
        else $error("node register not answered");
    chk_config_strobe: assert property ($rose(board_reg_sel) && access_write && host_long_word
        && reg_word == BRD_CONFIG |-> ##[0:2] cfg_wr)
        else $error("config strobe missing");
    chk_err_single: assert property (host_err |-> !host_ack ##1 !host_err)
        else $error("error answer not single");
endmodule
bind vme_slave_address_decoder vme_slave_address_decoder_sva #(
    .REG_QUAL(REG_QUAL), .BCAST_QUAL(BCAST_QUAL)
) i_vme_slave_address_decoder_sva (.sys_clk, .rst_b, .board_identifier, .host_addr,
    .host_addr_ext, .host_long_word, .mem_sel, .mem_node, .mem_dram, .mem_word,
    .node_reg_sel, .node_reg_node, .reg_word, .board_reg_sel, .bcast_sel, .access_write,
    .cfg_wr, .host_ack, .host_err, .bus_request);

//--- testbench/host_model.sv
// Host processor model: the only master on the backplane.
// Assumes answers come back as host_ack or host_err levels.
`timescale 1ns/1ps
module host_model (
    // Clock and answers
    input  wire logic        sys_clk,
    input  wire logic        host_ack,
    input  wire logic        host_err,
    // Cycle pins
    output logic      [31:0] host_addr,
    output logic             host_addr_ext,
    output logic             host_strobe_b,
    output logic             host_long_word,
    output logic             host_write,
    output logic             host_iack_b
);
    // Idle bus at time zero
    initial begin
        host_addr = 32'h0;
        host_addr_ext = 1'b0;
        host_strobe_b = 1'b1;
        host_long_word = 1'b1;
        host_write = 1'b0;
        host_iack_b = 1'b1;
    end
    // One cycle; held until an answer is sampled, bounded so a refusal ends
    task automatic access(input logic ext, input logic [31:0] addr, input logic wr,
                          input logic lw, input logic iack, output logic [1:0] resp);
        resp = 2'b00;
        @(negedge sys_clk);
        host_addr = addr;
        host_addr_ext = ext;
        host_write = wr;
        host_long_word = lw; // Narrow only when a refusal is wanted
        host_iack_b = !iack;
        host_strobe_b = 1'b0;
        for (int n = 0; n < 16 && resp == 2'b00; n++) begin
            @(posedge sys_clk);
            resp = {host_err, host_ack};
        end
        @(negedge sys_clk);
        host_strobe_b = 1'b1;
        host_iack_b = 1'b1;
        host_addr = ~addr; // Released bus must not show the old address
        repeat (4) @(negedge sys_clk);
    endtask
endmodule

//--- testbench/vme_slave_address_decoder_test.sv
// Self-checking bench for the backplane slave address decoder.
// Assumes the host model drives every host cycle pin.
`timescale 1ns/1ps
module vme_slave_address_decoder_test;
    import bus_decode_pkg::*;
    logic sys_clk, rst_b, irq_request, node_done, host_ack, host_err, irq_out, bus_request;
    logic [31:0] host_addr;
    logic host_addr_ext, host_strobe_b, host_long_word, host_write, host_iack_b;
    logic mem_sel, mem_dram, node_reg_sel, board_reg_sel, bcast_sel, access_write;
    logic [1:0] mem_node, node_reg_node;
    logic [21:0] mem_word;
    logic [2:0] reg_word;
    logic cfg_wr, vector_wr, link_load_wr, mem_load_wr;
    logic [7:0] vector_wdata, iack_vector, vec_seen;
    logic [3:0] board_identifier, strobes_seen;
    int fails = 0;
    int comparisons = 0;
    vme_slave_address_decoder i_vme_slave_address_decoder (.sys_clk, .rst_b, .board_identifier,
        .host_addr, .host_addr_ext, .host_strobe_b, .host_long_word, .host_write, .host_iack_b,
        .irq_request, .node_done, .mem_sel, .mem_node, .mem_dram, .mem_word, .node_reg_sel,
        .node_reg_node, .reg_word, .board_reg_sel, .bcast_sel, .access_write, .cfg_wr,
        .vector_wr, .link_load_wr, .mem_load_wr, .vector_wdata, .host_ack, .host_err,
        .iack_vector, .irq_out, .bus_request);
    host_model i_host_model (.sys_clk, .host_ack, .host_err, .host_addr, .host_addr_ext,
        .host_strobe_b, .host_long_word, .host_write, .host_iack_b);
    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Memory target finishes half a cycle after being selected
    always @(negedge sys_clk) node_done <= mem_sel;
    // Collect board strobes and the vector given during acknowledge
    always @(posedge sys_clk) begin
        strobes_seen <= strobes_seen | {mem_load_wr, link_load_wr, vector_wr, cfg_wr};
        if (host_ack && !host_iack_b) vec_seen <= iack_vector;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Short address from qualifier, identifier, bits 7:5 and word
    function automatic logic [31:0] sa(input logic [3:0] q, input logic [3:0] id,
                                       input logic [2:0] mid, input logic [2:0] w);
        return {16'h0, q, id, mid, w, 2'b00};
    endfunction
    task automatic go(input logic ext, input logic [31:0] a, input logic wr, input logic lw,
                      input logic [1:0] exp);
        logic [1:0] resp;
        i_host_model.access(ext, a, wr, lw, 1'b0, resp);
        check({30'h0, resp}, {30'h0, exp});
    endtask
    task automatic test_memory();
        for (int n = 0; n < 8; n++) begin
            go(1'b1, {1'b1, 4'h9, n[2:0], n[0] ? 22'h3fffff : 22'h0, 2'b00}, n[0], 1'b1, 2'b01);
        end
        go(1'b1, {1'b0, 4'h9, 27'h0}, 1'b0, 1'b1, 2'b00);
        go(1'b1, {1'b1, 4'h3, 27'h0}, 1'b0, 1'b1, 2'b00);
        go(1'b0, {1'b1, 4'h9, 27'h0}, 1'b0, 1'b1, 2'b00);
    endtask
    task automatic test_registers();
        for (int n = 0; n < 4; n++) begin
            go(1'b0, sa(4'hf, 4'h9, n[2:0], 3'h7), n[0], 1'b1, 2'b01);
        end
        go(1'b0, sa(4'hd, 4'h9, 3'h0, 3'h0), 1'b0, 1'b1, 2'b00);
        go(1'b0, sa(4'hf, 4'h3, 3'h0, 3'h0), 1'b0, 1'b1, 2'b00);
        go(1'b0, sa(4'hf, 4'h9, 3'h0, 3'h0), 1'b1, 1'b0, 2'b10);
    endtask
    task automatic test_board_strobes();
        for (int w = 0; w < 4; w++) begin
            strobes_seen = 4'h0;
            go(1'b0, sa(4'hf, 4'h9, 3'h4, w[2:0]), 1'b1, 1'b1, 2'b01);
            check({28'h0, strobes_seen}, 32'h1 << w);
        end
        go(1'b0, sa(4'hf, 4'h9, 3'h4, BRD_CONFIG), 1'b0, 1'b1, 2'b01);
        go(1'b0, sa(4'hf, 4'h9, 3'h4, 3'h4), 1'b1, 1'b1, 2'b00);
    endtask
    task automatic test_broadcast();
        for (int w = 0; w < 3; w++) begin
            go(1'b0, sa(4'he, 4'h0, {w[0], 2'b10}, w[2:0]), w != 1, 1'b1, 2'b01);
        end
        go(1'b0, sa(4'he, 4'h0, 3'h0, 3'h3), 1'b1, 1'b1, 2'b00);
        go(1'b0, sa(4'he, 4'h9, 3'h0, 3'h0), 1'b1, 1'b1, 2'b00);
    endtask
    task automatic test_interrupt();
        logic [1:0] resp;
        vector_wdata = 8'h5a;
        go(1'b0, sa(4'hf, 4'h9, 3'h4, BRD_VECTOR), 1'b1, 1'b1, 2'b01);
        irq_request = 1'b1;
        @(negedge sys_clk);
        irq_request = 1'b0;
        repeat (3) @(negedge sys_clk);
        check({31'h0, irq_out}, 32'h1);
        i_host_model.access(1'b0, 32'h0, 1'b0, 1'b1, 1'b1, resp);
        check({30'h0, resp}, 32'h1);
        check({24'h0, vec_seen}, 32'h5a);
        check({31'h0, irq_out}, 32'h0);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst_b = 1'b0;
        board_identifier = 4'h9;
        irq_request = 1'b0;
        vector_wdata = 8'h00;
        strobes_seen = 4'h0;
        repeat (10) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge sys_clk);
        test_memory();
        test_registers();
        test_board_strobes();
        test_broadcast();
        test_interrupt();
        give_verdict();
    end
    // Watchdog well beyond the roughly 400 cycles the tests need
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule
